// ==== hdl/dzg_trim_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dzg_trim_top (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [dzg_pkg::ADDR_W-1:0] addr_in,
  input wire logic [dzg_pkg::WORD_W-1:0] wdata_in,
  input wire logic load_in,
  input wire logic [dzg_pkg::NCH-1:0] unipolar_in,
  output logic [dzg_pkg::WORD_W-1:0] rdata_out,
  output logic rvalid_out,
  output logic [dzg_pkg::NCH-1:0][dzg_pkg::WORD_W-1:0] dac_code_out
);
  import dzg_pkg::*;
  typedef struct packed {
    logic [NCH-1:0][WORD_W-1:0] data;
    logic [NCH-1:0][WORD_W-1:0] dac;
    logic [WORD_W-1:0] rdata;
    logic rvalid;
  } dzg_main_t;
  dzg_main_t s_q;
  dzg_main_t s_d;
  logic [1:0] kind;
  logic [CHAN_W-1:0] chan;
  logic [NCH-1:0][OFFS_W-1:0] offs_code;
  logic [NCH-1:0][GAIN_W-1:0] gain_code;
  logic [NCH-1:0][WORD_W-1:0] offs_word;
  logic [NCH-1:0][WORD_W-1:0] gain_word;
  logic [NCH-1:0][WORD_W-1:0] corr_code;
  assign kind = addr_in[ADDR_W-1:CHAN_W];
  assign chan = addr_in[CHAN_W-1:0];
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    logic hit;
    assign hit = wr_en_in && (chan == CHAN_W'(g));
    dzg_trim_regs u_trim (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .wr_offs_in(hit && (kind == KIND_OFFS)), // see (RL1)
      .wr_gain_in(hit && (kind == KIND_GAIN)), // see (RL1)
      .wdata_in(wdata_in),
      .offs_code_out(offs_code[g]),
      .gain_code_out(gain_code[g]),
      .offs_word_out(offs_word[g]),
      .gain_word_out(gain_word[g])
    );
    dzg_corrector u_corr (
      .unipolar_in(unipolar_in[g]),
      .code_in(s_q.data[g]),
      .offs_code_in(offs_code[g]),
      .gain_code_in(gain_code[g]),
      .code_out(corr_code[g])
    );
  end
  // A load in the same cycle as a data or trim write uses the old values;
  // this keeps the update path one register deep at the full clock rate.
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    if (wr_en_in && kind == KIND_DATA) begin
      s_d.data[chan] = wdata_in;
    end
    if (load_in) begin
      s_d.dac = corr_code; // see (RL13) (RL10)
    end
    if (rd_en_in) begin
      s_d.rvalid = 1'b1;
      case (kind)
        KIND_DATA: s_d.rdata = s_q.data[chan];
        KIND_OFFS: s_d.rdata = offs_word[chan]; // see (RL8)
        KIND_GAIN: s_d.rdata = gain_word[chan]; // see (RL8)
        default: s_d.rdata = DATA_RESET;
      endcase
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign rdata_out = s_q.rdata;
  assign rvalid_out = s_q.rvalid;
  assign dac_code_out = s_q.dac;

  logic wr_offs;
  logic wr_gain;
  logic rd_offs;
  logic rd_gain;
  assign wr_offs = wr_en_in && kind == KIND_OFFS;
  assign wr_gain = wr_en_in && kind == KIND_GAIN;
  assign rd_offs = rd_en_in && kind == KIND_OFFS;
  assign rd_gain = rd_en_in && kind == KIND_GAIN;

  property p_offs_wr;
    @(posedge mclk_in) disable iff (!rst_n_in)
    wr_offs |=> offs_code[$past(chan)] == $past(wdata_in[OFFS_W-1:0]);
  endproperty
  a_offs_wr: assert property (p_offs_wr) // see (RL2)
    else $error("Offset trim did not take the written code.");

  property p_gain_wr;
    @(posedge mclk_in) disable iff (!rst_n_in)
    wr_gain |=> gain_code[$past(chan)] == $past(wdata_in[GAIN_W-1:0]);
  endproperty
  a_gain_wr: assert property (p_gain_wr) // see (RL4)
    else $error("Gain trim did not take the written code.");

  property p_offs_indep;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_offs && !wr_gain) |=> $stable(gain_code);
  endproperty
  a_offs_indep: assert property (p_offs_indep) // see (RL1)
    else $error("Offset write disturbed a gain trim.");

  property p_chan_indep;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_offs && chan != CHAN_W'(0)) |=> $stable(offs_code[0]);
  endproperty
  a_chan_indep: assert property (p_chan_indep) // see (RL1)
    else $error("Offset write to another channel changed channel zero.");

  property p_offs_rd;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (rd_offs && !wr_offs) |=> rvalid_out
      && rdata_out[WORD_W-1:OFFS_W] == '0
      && rdata_out[OFFS_W-1:0] == offs_code[$past(chan)];
  endproperty
  a_offs_rd: assert property (p_offs_rd) // see (RL8)
    else $error("Offset readback wrong or reserved bits set.");

  property p_gain_rd;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (rd_gain && !wr_gain) |=> rvalid_out
      && rdata_out[WORD_W-1:GAIN_W] == '0
      && rdata_out[GAIN_W-1:0] == gain_code[$past(chan)];
  endproperty
  a_gain_rd: assert property (p_gain_rd) // see (RL8)
    else $error("Gain readback wrong or reserved bits set.");

  property p_gain_reset;
    @(posedge mclk_in)
    !rst_n_in |=> gain_code == '0;
  endproperty
  a_gain_reset: assert property (p_gain_reset) // see (RL9)
    else $error("Gain trims not cleared by reset.");

  property p_offs_reset;
    @(posedge mclk_in)
    !rst_n_in |=> offs_code == '0;
  endproperty
  a_offs_reset: assert property (p_offs_reset) // see (RL12)
    else $error("Offset trims not cleared by reset.");

  property p_load;
    @(posedge mclk_in) disable iff (!rst_n_in)
    load_in |=> dac_code_out == $past(corr_code);
  endproperty
  a_load: assert property (p_load) // see (RL13)
    else $error("Output did not take the corrected code on load.");

  property p_hold;
    @(posedge mclk_in) disable iff (!rst_n_in)
    !load_in |=> $stable(dac_code_out);
  endproperty
  a_hold: assert property (p_hold) // see (RL13)
    else $error("Output changed without a load.");

  property p_no_trim;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (load_in && offs_code[0] == '0 && gain_code[0] == '0)
      |=> dac_code_out[0] == $past(s_q.data[0]);
  endproperty
  a_no_trim: assert property (p_no_trim) // see (RL11)
    else $error("Zero trims altered the output code.");

  property p_offs_step;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (load_in && unipolar_in[0] && gain_code[0] == '0
      && offs_code[0] == OFFS_ONE_LSB && s_q.data[0] != UNI_TOP)
      |=> dac_code_out[0] == $past(s_q.data[0]) + 16'h0001;
  endproperty
  a_offs_step: assert property (p_offs_step) // see (RL3)
    else $error("Eight offset steps did not move the output one LSB.");

  property p_gain_uni;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (load_in && unipolar_in[0] && offs_code[0] == '0
      && gain_code[0] == GAIN_MOST_NEG && s_q.data[0] == UNI_TOP)
      |=> dac_code_out[0] == UNI_TOP_G128;
  endproperty
  a_gain_uni: assert property (p_gain_uni) // see (RL6) (RL10)
    else $error("Unipolar full-scale gain correction wrong.");

  property p_gain_bip;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (load_in && !unipolar_in[0] && offs_code[0] == '0
      && gain_code[0] == GAIN_MOST_NEG && s_q.data[0] == BIP_TOP)
      |=> dac_code_out[0] == BIP_TOP_G128;
  endproperty
  a_gain_bip: assert property (p_gain_bip) // see (RL7) (RL5)
    else $error("Bipolar full-scale gain correction wrong.");

  property p_bip_bottom;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (load_in && !unipolar_in[0] && offs_code[0] == '0
      && gain_code[0] == '0 && s_q.data[0] == BIP_BOTTOM)
      |=> dac_code_out[0] == BIP_BOTTOM;
  endproperty
  a_bip_bottom: assert property (p_bip_bottom) // see (RL11)
    else $error("Bipolar negative full scale not passed through.");

  property p_gain_indep;
    @(posedge mclk_in) disable iff (!rst_n_in)
    wr_gain |=> $stable(offs_code);
  endproperty
  a_gain_indep: assert property (p_gain_indep) // see (RL1)
    else $error("Gain write disturbed an offset trim.");

  property p_chan_indep_gain;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_gain && chan != CHAN_W'(0)) |=> $stable(gain_code[0]);
  endproperty
  a_chan_indep_gain: assert property (p_chan_indep_gain) // see (RL1)
    else $error("Gain write to another channel changed channel zero.");

  property p_unmapped_wr;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_en_in && kind == '0) |=> $stable(offs_code)
      && $stable(gain_code) && $stable(s_q.data);
  endproperty
  a_unmapped_wr: assert property (p_unmapped_wr) // see (RL1)
    else $error("Write to an unmapped address changed a register.");

  property p_unmapped_rd;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (rd_en_in && kind == '0) |=> rvalid_out && rdata_out == '0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) // see (RL8)
    else $error("Read of an unmapped address was not zero.");

  property p_rvalid_once;
    @(posedge mclk_in) disable iff (!rst_n_in)
    !rd_en_in |=> !rvalid_out;
  endproperty
  a_rvalid_once: assert property (p_rvalid_once) // see (RL8)
    else $error("Read valid raised without a read request.");

  property p_data_wr;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_en_in && kind == KIND_DATA) |=> s_q.data[$past(chan)] == $past(wdata_in);
  endproperty
  a_data_wr: assert property (p_data_wr) // see (RL11)
    else $error("Input data register did not take the written code.");

  property p_data_rd;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (rd_en_in && !wr_en_in && kind == KIND_DATA)
      |=> rvalid_out
      && rdata_out == s_q.data[$past(chan)];
  endproperty
  a_data_rd: assert property (p_data_rd) // see (RL11)
    else $error("Input data readback wrong.");

  property p_offs_neg_step;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (load_in && unipolar_in[0] && gain_code[0] == '0
      && offs_code[0] == -OFFS_ONE_LSB
      && s_q.data[0] != UNI_MIN[WORD_W-1:0])
      |=> dac_code_out[0] == $past(s_q.data[0]) - 16'h0001;
  endproperty
  a_offs_neg_step: assert property (p_offs_neg_step) // see (RL3)
    else $error("Minus eight offset steps did not lower the output one LSB.");

  property p_uni_floor;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (load_in && unipolar_in[1] && gain_code[1] == '0
      && offs_code[1][OFFS_W-1] && s_q.data[1] == UNI_MIN[WORD_W-1:0])
      |=> dac_code_out[1] == UNI_MIN[WORD_W-1:0];
  endproperty
  a_uni_floor: assert property (p_uni_floor) // see (RL3)
    else $error("Negative offset at unipolar zero did not hold at zero.");

  property p_bip_ceiling;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (load_in && !unipolar_in[0] && gain_code[0] == '0
      && offs_code[0] == OFFS_ONE_LSB && s_q.data[0] == BIP_TOP)
      |=> dac_code_out[0] == BIP_TOP;
  endproperty
  a_bip_ceiling: assert property (p_bip_ceiling) // see (RL3)
    else $error("Bipolar positive full scale did not saturate.");

  property p_gain_pos;
    @(posedge mclk_in) disable iff (!rst_n_in)
    (load_in && unipolar_in[0] && offs_code[0] == '0
      && gain_code[0] == ~GAIN_MOST_NEG && s_q.data[0] == UNI_TOP)
      |=> dac_code_out[0] == UNI_TOP;
  endproperty
  a_gain_pos: assert property (p_gain_pos) // see (RL6)
    else $error("Largest positive gain at full scale did not saturate.");

  property p_out_reset;
    @(posedge mclk_in)
    !rst_n_in |=> !rvalid_out && dac_code_out == '0;
  endproperty
  a_out_reset: assert property (p_out_reset) // see (RL12)
    else $error("Outputs not cleared by reset.");
endmodule
`default_nettype wire

// ==== hdl/dzg_pkg.sv ====
// Function
// (RL1) Every one of the four channels owns its own offset trim and gain trim.
// (RL2) The offset trim code sits in bits 8:0 and bits 15:9 are reserved.
// (RL3) The offset code is two's complement in eighth-LSB steps, -32 to +31.875.
// (RL4) The gain trim code sits in bits 7:0 and bits 15:8 are reserved.
// (RL5) One step of the gain code is one LSB of gain correction; the code moves the bipolar top of span half an LSB per step.
// (RL6) The gain code spans -128 to +127 LSB and zero applies no correction.
// (RL7) The gain code is two's complement in bipolar and unipolar operation.
// (RL8) Reserved trim bits ignore writes and always read back as zero.
// (RL9) Reset clears every gain trim so no gain correction is applied.
// (RL10) The gain trim removes gain error from the channel's output code.
// (RL11) Input codes are two's complement when bipolar, straight when unipolar.
// (RL12) The offset trim is two's complement in both modes and resets to zero.
// (RL13) Trims are applied on every output update, so changes act on the next.
package dzg_pkg;
  localparam int NCH = 4;
  localparam int CHAN_W = 2;
  localparam int ADDR_W = 4;
  localparam int WORD_W = 16;
  localparam int OFFS_W = 9;
  localparam int GAIN_W = 8;
  localparam int FRAC_W = 3;
  localparam int GAIN_SHIFT = 13;
  localparam int ACC_W = 22;
  localparam logic [1:0] KIND_DATA = 2'h1;
  localparam logic [1:0] KIND_OFFS = 2'h2;
  localparam logic [1:0] KIND_GAIN = 2'h3;
  localparam logic [WORD_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [OFFS_W-1:0] OFFS_RESET = 9'h000;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 8'h00;
  localparam logic [ACC_W-1:0] ROUND_HALF = 22'h000004;
  localparam logic signed [ACC_W-1:0] UNI_MAX = 22'sh00ffff;
  localparam logic signed [ACC_W-1:0] UNI_MIN = 22'sh000000;
  localparam logic signed [ACC_W-1:0] BIP_MAX = 22'sh007fff;
  localparam logic signed [ACC_W-1:0] BIP_MIN = 22'sh3f8000;
  localparam logic [OFFS_W-1:0] OFFS_ONE_LSB = 9'h008;
  localparam logic [GAIN_W-1:0] GAIN_MOST_NEG = 8'h80;
  localparam logic [WORD_W-1:0] UNI_TOP = 16'hffff;
  localparam logic [WORD_W-1:0] UNI_TOP_G128 = 16'hff7f;
  localparam logic [WORD_W-1:0] BIP_TOP = 16'h7fff;
  localparam logic [WORD_W-1:0] BIP_TOP_G128 = 16'h7fbf;
  localparam logic [WORD_W-1:0] BIP_BOTTOM = 16'h8000;
endpackage

// ==== hdl/dzg_trim_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module dzg_trim_regs (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wr_offs_in,
  input wire logic wr_gain_in,
  input wire logic [dzg_pkg::WORD_W-1:0] wdata_in,
  output logic [dzg_pkg::OFFS_W-1:0] offs_code_out,
  output logic [dzg_pkg::GAIN_W-1:0] gain_code_out,
  output logic [dzg_pkg::WORD_W-1:0] offs_word_out,
  output logic [dzg_pkg::WORD_W-1:0] gain_word_out
);
  import dzg_pkg::*;
  typedef struct packed {
    logic [OFFS_W-1:0] offs;
    logic [GAIN_W-1:0] gain;
  } dzg_trim_t;
  dzg_trim_t s_q;
  dzg_trim_t s_d;
  // Only the code bits are stored, so reserved bits cannot hold anything.
  always_comb begin
    s_d = s_q;
    if (wr_offs_in) begin
      s_d.offs = wdata_in[OFFS_W-1:0]; // see (RL2) (RL8)
    end
    if (wr_gain_in) begin
      s_d.gain = wdata_in[GAIN_W-1:0]; // see (RL4) (RL8)
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_q.offs <= OFFS_RESET; // see (RL12)
      s_q.gain <= GAIN_RESET; // see (RL9)
    end else begin
      s_q <= s_d;
    end
  end
  assign offs_code_out = s_q.offs;
  assign gain_code_out = s_q.gain;
  assign offs_word_out = {{(WORD_W-OFFS_W){1'b0}}, s_q.offs}; // see (RL8)
  assign gain_word_out = {{(WORD_W-GAIN_W){1'b0}}, s_q.gain}; // see (RL8)
endmodule
`default_nettype wire

// ==== hdl/dzg_corrector.sv ====
`timescale 1ns/1ps
`default_nettype none
module dzg_corrector (
  input wire logic unipolar_in,
  input wire logic [dzg_pkg::WORD_W-1:0] code_in,
  input wire logic [dzg_pkg::OFFS_W-1:0] offs_code_in,
  input wire logic [dzg_pkg::GAIN_W-1:0] gain_code_in,
  output logic [dzg_pkg::WORD_W-1:0] code_out
);
  import dzg_pkg::*;
  logic signed [WORD_W:0] val;
  logic signed [WORD_W+GAIN_W:0] prod;
  logic signed [WORD_W+GAIN_W:0] gterm;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] rnd;
  // Work in eighth-LSB fixed point so the offset step is exact; the gain
  // term scales with the code so a trim of g moves the unipolar top of span by g, the bipolar top by g/2.
  always_comb begin
    if (unipolar_in) begin
      val = $signed({1'b0, code_in}); // see (RL11)
    end else begin
      val = $signed({code_in[WORD_W-1], code_in}); // see (RL11)
    end
    prod = $signed(gain_code_in) * val; // see (RL5) (RL6) (RL7) (RL10)
    gterm = prod >>> GAIN_SHIFT;
    acc = (ACC_W'(val) <<< FRAC_W) + gterm[ACC_W-1:0]
        + ACC_W'($signed(offs_code_in)); // see (RL3) (RL12)
    rnd = (acc + $signed(ROUND_HALF)) >>> FRAC_W;
    // Saturate rather than wrap: a trim must never fold the output over.
    if (unipolar_in && rnd > UNI_MAX) begin
      code_out = UNI_MAX[WORD_W-1:0];
    end else if (unipolar_in && rnd < UNI_MIN) begin
      code_out = UNI_MIN[WORD_W-1:0];
    end else if (!unipolar_in && rnd > BIP_MAX) begin
      code_out = BIP_MAX[WORD_W-1:0];
    end else if (!unipolar_in && rnd < BIP_MIN) begin
      code_out = BIP_MIN[WORD_W-1:0];
    end else begin
      code_out = rnd[WORD_W-1:0];
    end
  end
endmodule
`default_nettype wire

// ==== dv/dzg_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dzg_host_model (
  input wire logic mclk_in,
  input wire logic rvalid_in,
  input wire logic [dzg_pkg::WORD_W-1:0] rdata_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [dzg_pkg::ADDR_W-1:0] addr_out,
  output logic [dzg_pkg::WORD_W-1:0] wdata_out
);
  import dzg_pkg::*;
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 4'h0;
    wdata_out = 16'h0000;
  end
  // Released lines show inverted values so a stale sample cannot pass.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    #1;
    wr_en_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(posedge mclk_in);
    #1;
    wr_en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge mclk_in);
    #1;
    rd_en_out = 1'b1;
    addr_out = a;
    @(posedge mclk_in);
    #1;
    rd_en_out = 1'b0;
    addr_out = ~a;
    v = rvalid_in;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

// ==== dv/dzg_trim_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module dzg_trim_top_bench;
  import dzg_pkg::*;
  logic mclk, rst_n, load, wr_en, rd_en, rvalid;
  logic [3:0] uni, addr;
  logic [15:0] wdata, rdata;
  logic [NCH-1:0][WORD_W-1:0] dac;
  logic [15:0] dv [4];
  logic [8:0] zv [4];
  logic [7:0] gv [4];
  int miscompares = 0;
  int cmp_count = 0;
  dzg_host_model host (.mclk_in(mclk), .rvalid_in(rvalid),
    .rdata_in(rdata), .wr_en_out(wr_en), .rd_en_out(rd_en),
    .addr_out(addr), .wdata_out(wdata));
  dzg_trim_top dut (.mclk_in(mclk), .rst_n_in(rst_n), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .load_in(load),
    .unipolar_in(uni), .rdata_out(rdata), .rvalid_out(rvalid),
    .dac_code_out(dac));
  always #2.5 mclk = ~mclk;
  // Arithmetic shifts on longint give floor division for negative sums.
  function automatic logic [15:0] ref_out(logic u, logic [15:0] d,
                                          logic [8:0] z, logic [7:0] g);
    longint v, acc, o;
    v = u ? longint'(d) : longint'($signed(d));
    acc = 8 * v + ((longint'($signed(g)) * v) >>> 13);
    acc = acc + longint'($signed(z));
    o = (acc + 4) >>> 3;
    if (u) o = (o > 65535) ? 65535 : ((o < 0) ? 0 : o);
    else o = (o > 32767) ? 32767 : ((o < -32768) ? -32768 : o);
    return o[15:0];
  endfunction
  task automatic chk(input logic [15:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    host.rd(a, d, v);
    chk({15'h0000, v}, 16'h0001, "read valid");
    chk(d, exp, "read data");
  endtask
  task automatic pulse_load();
    @(posedge mclk);
    #1;
    load = 1'b1;
    @(posedge mclk);
    #1;
    load = 1'b0;
  endtask
  task automatic check_all();
    for (int n = 0; n < 4; n++)
      chk(dac[n], ref_out(uni[n], dv[n], zv[n], gv[n]), "output code");
  endtask
  task automatic run_case(input int c, input logic u, input logic [15:0] d,
                          input logic [8:0] z, input logic [7:0] g);
    host.wr(4'h4 + c[3:0], d);
    host.wr(4'h8 + c[3:0], {7'h7f, z});
    host.wr(4'hc + c[3:0], {8'hff, g});
    rchk(4'h4 + c[3:0], d);
    dv[c] = d;
    zv[c] = z;
    gv[c] = g;
    uni[c] = u;
    pulse_load();
    check_all();
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    load = 1'b0;
    uni = 4'h0;
    for (int n = 0; n < 4; n++) begin
      dv[n] = 16'h0000;
      zv[n] = 9'h000;
      gv[n] = 8'h00;
    end
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (int a = 0; a < 16; a++) rchk(a[3:0], 16'h0000);
    pulse_load();
    check_all();
    $display("test reset done");
    for (int n = 0; n < 4; n++) begin
      host.wr(4'h8 + n[3:0], 16'hff30 + n[15:0]);
      host.wr(4'hc + n[3:0], 16'hff80 + n[15:0]);
    end
    host.wr(4'h2, 16'hffff);
    for (int n = 0; n < 4; n++) begin
      rchk(4'h8 + n[3:0], 16'h0130 + n[15:0]);
      rchk(4'hc + n[3:0], 16'h0080 + n[15:0]);
      zv[n] = 9'h130 + n[8:0];
      gv[n] = 8'h80 + n[7:0];
    end
    rchk(4'h2, 16'h0000);
    $display("test fields done");
    run_case(0, 1'b1, 16'h1000, 9'h008, 8'h00);
    run_case(0, 1'b1, 16'h1000, 9'h1f8, 8'h00);
    run_case(0, 1'b0, 16'h7fff, 9'h000, 8'h80);
    run_case(0, 1'b0, 16'h8000, 9'h000, 8'h00);
    run_case(0, 1'b0, 16'h7fff, 9'h008, 8'h00);
    run_case(0, 1'b1, 16'hffff, 9'h000, 8'h7f);
    run_case(0, 1'b1, 16'hffff, 9'h000, 8'h80);
    run_case(1, 1'b0, 16'h7fff, 9'h000, 8'h80);
    run_case(2, 1'b1, 16'h1000, 9'h008, 8'h00);
    run_case(3, 1'b0, 16'h0000, 9'h100, 8'h00);
    run_case(0, 1'b0, 16'h8000, 9'h1ff, 8'h7f);
    run_case(1, 1'b1, 16'h0000, 9'h1ff, 8'h00);
    run_case(2, 1'b1, 16'hfff0, 9'h0ff, 8'h7f);
    run_case(3, 1'b0, 16'hc000, 9'h0ff, 8'hff);
    $display("test correction done");
    // A write landing on the load edge must not reach that load.
    fork
      host.wr(4'hc, 16'h0040);
      pulse_load();
    join
    check_all();
    gv[0] = 8'h40;
    pulse_load();
    check_all();
    $display("test update done");
    // Reset again after trims were written, so the clear is really seen.
    rst_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (int n = 0; n < 4; n++) begin
      dv[n] = 16'h0000;
      zv[n] = 9'h000;
      gv[n] = 8'h00;
    end
    for (int n = 0; n < 4; n++) begin
      rchk(4'h8 + n[3:0], 16'h0000);
      rchk(4'hc + n[3:0], 16'h0000);
    end
    check_all();
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
